// *** gpt_fe_store.sv ***
// Purpose: front-end register store with deferred or immediate update per address
// Assumes: one write port, one registered read port of the active values
// Notes: a deferred write in the same cycle as vertical_drive is kept pending for the next one
`timescale 1ns/10ps
module gpt_fe_store (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_addr,
	input  wire logic [27:0] wr_data,
	input  wire logic [15:0] direct_mask,
	input  wire logic        vertical_drive,
	input  wire logic [3:0]  rd_addr,
	output logic      [27:0] rd_data
);

	logic [27:0] staged [gpt_pkg::NUM_FE_REGS];
	logic [27:0] active [gpt_pkg::NUM_FE_REGS];
	logic [15:0] pending;

	genvar n;
	generate
		for (n = 0; n < gpt_pkg::NUM_FE_REGS; n++) begin : g_entry
			wire hit    = wr_en && (wr_addr == 4'(n));
			wire direct = hit && direct_mask[n];
			wire commit = vertical_drive && pending[n];
			// an older pending value still goes live at vertical drive even when a new deferred write lands then
			always_ff @(posedge clock) begin
				if (rst) begin
					staged[n]  <= gpt_pkg::TOGGLE_RESET;
					active[n]  <= gpt_pkg::TOGGLE_RESET;
					pending[n] <= 1'b0;
				end else begin
					if (direct)
						active[n] <= wr_data;
					else if (commit)
						active[n] <= staged[n];
					if (hit && !direct)
						staged[n] <= wr_data;
					pending[n] <= (hit && !direct) || (pending[n] && !vertical_drive && !direct);
				end
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst)
			rd_data <= gpt_pkg::TOGGLE_RESET;
		else
			rd_data <= active[rd_addr];
	end

	direct_write_a: assert property (@(posedge clock) disable iff (rst)
		wr_en && direct_mask[wr_addr] |=> active[$past(wr_addr)] == $past(wr_data))
		else $error("masked front-end write did not load at once");

	deferred_write_a: assert property (@(posedge clock) disable iff (rst)
		wr_en && !direct_mask[wr_addr] && !vertical_drive |=> active[$past(wr_addr)] == $past(active[wr_addr]))
		else $error("unmasked front-end write loaded before vertical drive");

	direct_write_c: cover property (@(posedge clock) disable iff (rst) wr_en && direct_mask[wr_addr]);

endmodule // gpt_fe_store

// *** gpt_pkg.sv ***
// Purpose: shared constants and types for the general output toggle register bank
// Assumes: register indices are word indices; byte address is four times the index
// Notes: widths are fixed
package gpt_pkg;

	localparam logic [7:0]  IDX_OUT1_A      = 8'h54;
	localparam logic [7:0]  IDX_OUT1_B      = 8'h55;
	localparam logic [7:0]  IDX_OUT1_C      = 8'h56;
	localparam logic [7:0]  IDX_OUT2_A      = 8'h57;
	localparam logic [7:0]  IDX_OUT2_B      = 8'h58;
	localparam logic [7:0]  IDX_OUT2_C      = 8'h59;
	localparam logic [7:0]  IDX_UNUSED_LO   = 8'h5A;
	localparam logic [7:0]  IDX_UNUSED_HI   = 8'h5F;
	localparam logic [7:0]  IDX_FE_MASK     = 8'h60;
	localparam logic [7:0]  IDX_LEVEL_CTRL  = 8'h61;
	localparam logic [7:0]  IDX_FE_LAST     = 8'h0F;

	localparam int          WORDS_PER_OUT   = 3;
	localparam int          NUM_TOGGLE_REGS = 6;
	localparam int          NUM_FE_REGS     = 16;

	// field positions inside the toggle words
	localparam int          A_FIELD_LSB     = 0;
	localparam int          A_LINE_LSB      = 13;
	localparam int          B_PIXEL_LSB     = 0;
	localparam int          B_FIELD_LSB     = 13;
	localparam int          C_LINE_LSB      = 0;
	localparam int          C_PIXEL_LSB     = 13;
	localparam int          FIELD_W         = 4;
	localparam int          COUNT_W         = 13;
	localparam int          REG_W           = 28;

	localparam logic [27:0] MASK_WORD_A     = 28'h3FFE00F;
	localparam logic [27:0] MASK_WORD_B     = 28'h001FFFF;
	localparam logic [27:0] MASK_WORD_C     = 28'h3FFFFFF;

	localparam logic [27:0] TOGGLE_RESET    = 28'h0000000;
	localparam logic [15:0] FE_MASK_RESET   = 16'h1803;
	localparam logic [1:0]  LEVEL_RESET     = 2'h0;

	// level control word: start levels writable, output levels read only
	localparam int          LVL_START_LSB   = 0;
	localparam int          LVL_OUT_LSB     = 2;

	typedef struct packed {
		logic [3:0]  field;
		logic [12:0] line;
		logic [12:0] pixel;
	} gpt_point_type;

	typedef struct packed {
		gpt_point_type first;
		gpt_point_type second;
	} gpt_output_cfg_type;

endpackage

// *** gpt_toggle_regs.sv ***
// Purpose: toggle position registers for two general outputs and front-end update mask
// Assumes: classic Wishbone slave, counters synchronous to clock
// Notes: toggle positions go live only on vertical_drive
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// - output one first point field, line, pixel
// - output one second point field, line, pixel
// - output two first point, same layout
// - output two second point, same layout
// - positions reset zero, apply at vertical drive
// - sixteen-bit update mask, reset 1803
// - masked front-end register loads on full-word write
// - outputs start at programmable level
module gpt_toggle_regs (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        vertical_drive,
	input  wire logic        frame_start,
	input  wire logic [3:0]  field_count,
	input  wire logic [12:0] line_count,
	input  wire logic [12:0] pixel_count,
	output logic             general_output_one,
	output logic             general_output_two
);

	logic [27:0]                 staged [gpt_pkg::NUM_TOGGLE_REGS];
	gpt_pkg::gpt_output_cfg_type staged_cfg [2];
	gpt_pkg::gpt_output_cfg_type active_cfg [2];
	logic [15:0]                 frontend_serial_update_mask;
	logic [1:0]                  start_level;
	logic [1:0]                  level;
	logic                        wait_q;
	logic [27:0]                 fe_rd_data;

	// bus decode
	wire        req        = wb_cyc_i && wb_stb_i;
	wire        next_ack   = req && wait_q && !wb_ack_o;
	wire [7:0]  idx        = wb_adr_i[9:2];
	wire [31:0] byte_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire        do_write   = next_ack && wb_we_i;
	wire        fe_hit     = (idx <= gpt_pkg::IDX_FE_LAST);
	wire        spare_hit  = (idx >= gpt_pkg::IDX_UNUSED_LO) && (idx <= gpt_pkg::IDX_UNUSED_HI);
	wire        mask_hit   = (idx == gpt_pkg::IDX_FE_MASK);
	wire        level_hit  = (idx == gpt_pkg::IDX_LEVEL_CTRL);
	wire        fe_write   = do_write && fe_hit && (wb_sel_i == 4'hF);
	wire [15:0] next_mask  = (frontend_serial_update_mask & ~byte_mask[15:0]) | (wb_dat_i[15:0] & byte_mask[15:0]);
	wire [1:0]  next_start = (start_level & ~byte_mask[1:0]) | (wb_dat_i[1:0] & byte_mask[1:0]);

	logic [27:0] toggle_rd;
	wire  [3:0]  level_word = {level, start_level};

	wire [31:0] next_rdata =
		fe_hit    ? {4'h0, fe_rd_data} :
		spare_hit ? 32'h00000000 :
		mask_hit  ? {16'h0000, frontend_serial_update_mask} :
		level_hit ? {28'h0000000, level_word} :
		{4'h0, toggle_rd};

	localparam logic [27:0] WORD_MASK [gpt_pkg::NUM_TOGGLE_REGS] = '{
		gpt_pkg::MASK_WORD_A, gpt_pkg::MASK_WORD_B, gpt_pkg::MASK_WORD_C,
		gpt_pkg::MASK_WORD_A, gpt_pkg::MASK_WORD_B, gpt_pkg::MASK_WORD_C};

	always_comb begin
		toggle_rd = 28'h0000000;
		for (int w = 0; w < gpt_pkg::NUM_TOGGLE_REGS; w++) begin
			if (idx == gpt_pkg::IDX_OUT1_A + 8'(w))
				toggle_rd = staged[w];
		end
	end

	// toggle words: reserved bits are dropped on write and read as zero
	genvar w;
	generate
		for (w = 0; w < gpt_pkg::NUM_TOGGLE_REGS; w++) begin : g_word
			wire        hit    = do_write && (idx == gpt_pkg::IDX_OUT1_A + 8'(w));
			wire [27:0] merged = (staged[w] & ~byte_mask[27:0]) | (wb_dat_i[27:0] & byte_mask[27:0]);
			always_ff @(posedge clock) begin
				if (rst)
					staged[w] <= gpt_pkg::TOGGLE_RESET;
				else if (hit)
					staged[w] <= merged & WORD_MASK[w];
			end
		end
	endgenerate

	// per output: decode fields, commit at vertical drive, toggle on match
	genvar o;
	generate
		for (o = 0; o < 2; o++) begin : g_out
			localparam int B = o * gpt_pkg::WORDS_PER_OUT;
			wire [27:0] wa = staged[B];
			wire [27:0] wb = staged[B + 1];
			wire [27:0] wc = staged[B + 2];
			assign staged_cfg[o].first.field  = wa[gpt_pkg::A_FIELD_LSB +: gpt_pkg::FIELD_W];
			assign staged_cfg[o].first.line   = wa[gpt_pkg::A_LINE_LSB +: gpt_pkg::COUNT_W];
			assign staged_cfg[o].first.pixel  = wb[gpt_pkg::B_PIXEL_LSB +: gpt_pkg::COUNT_W];
			assign staged_cfg[o].second.field = wb[gpt_pkg::B_FIELD_LSB +: gpt_pkg::FIELD_W];
			assign staged_cfg[o].second.line  = wc[gpt_pkg::C_LINE_LSB +: gpt_pkg::COUNT_W];
			assign staged_cfg[o].second.pixel = wc[gpt_pkg::C_PIXEL_LSB +: gpt_pkg::COUNT_W];

			wire hit_first  = active_cfg[o].first  == {field_count, line_count, pixel_count};
			wire hit_second = active_cfg[o].second == {field_count, line_count, pixel_count};
			wire next_level = frame_start ? start_level[o] :
				(hit_first || hit_second) ? !level[o] : level[o];

			always_ff @(posedge clock) begin
				if (rst)
					active_cfg[o] <= '0;
				else if (vertical_drive)
					active_cfg[o] <= staged_cfg[o];
			end

			always_ff @(posedge clock) begin
				if (rst)
					level[o] <= gpt_pkg::LEVEL_RESET[o];
				else
					level[o] <= next_level;
			end
		end
	endgenerate

	assign general_output_one = level[0];
	assign general_output_two = level[1];

	always_ff @(posedge clock) begin
		if (rst) begin
			wait_q   <= 1'b0;
			wb_ack_o <= 1'b0;
		end else begin
			wait_q   <= req && !wait_q && !wb_ack_o;
			wb_ack_o <= next_ack;
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			wb_dat_o <= 32'h00000000;
		else if (next_ack)
			wb_dat_o <= next_rdata;
	end

	always_ff @(posedge clock) begin
		if (rst)
			frontend_serial_update_mask <= gpt_pkg::FE_MASK_RESET;
		else if (do_write && mask_hit)
			frontend_serial_update_mask <= next_mask;
	end

	always_ff @(posedge clock) begin
		if (rst)
			start_level <= gpt_pkg::LEVEL_RESET;
		else if (do_write && level_hit)
			start_level <= next_start;
	end

	gpt_fe_store u_fe_store (
		.clock          (clock),
		.rst            (rst),
		.wr_en          (fe_write),
		.wr_addr        (idx[3:0]),
		.wr_data        (wb_dat_i[27:0]),
		.direct_mask    (frontend_serial_update_mask),
		.vertical_drive (vertical_drive),
		.rd_addr        (idx[3:0]),
		.rd_data        (fe_rd_data)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	ack_latency_a: assert property ($rose(req) && !wb_ack_o |-> ##2 wb_ack_o)
		else $error("ack not two cycles after request");

	toggle_reset_a: assert property ($fell(rst) |-> active_cfg[0] == '0 && active_cfg[1] == '0 && staged[0] == '0)
		else $error("toggle positions not zero after reset");

	vd_commit_a: assert property (vertical_drive |=> active_cfg[1] == $past(staged_cfg[1]))
		else $error("positions not committed at vertical drive");

	hold_until_vd_a: assert property (!vertical_drive |=> $stable(active_cfg[0]))
		else $error("positions changed without vertical drive");

	mask_reset_a: assert property ($fell(rst) |-> frontend_serial_update_mask == gpt_pkg::FE_MASK_RESET)
		else $error("update mask reset value wrong");

	first_point_a: assert property (do_write && idx == gpt_pkg::IDX_OUT1_A && wb_sel_i == 4'hF
		|=> staged_cfg[0].first.field == $past(wb_dat_i[3:0])
			&& staged_cfg[0].first.line == $past(wb_dat_i[25:13]))
		else $error("output one first point layout wrong");

	second_field_a: assert property (do_write && idx == gpt_pkg::IDX_OUT1_B && wb_sel_i == 4'hF
		|=> staged_cfg[0].second.field == $past(wb_dat_i[16:13])
			&& staged_cfg[0].first.pixel == $past(wb_dat_i[12:0]))
		else $error("output one second field layout wrong");

	out_two_first_a: assert property (do_write && idx == gpt_pkg::IDX_OUT2_A && wb_sel_i == 4'hF
		|=> staged_cfg[1].first.line == $past(wb_dat_i[25:13]))
		else $error("output two first point layout wrong");

	out_two_second_a: assert property (do_write && idx == gpt_pkg::IDX_OUT2_C && wb_sel_i == 4'hF
		|=> staged_cfg[1].second.line == $past(wb_dat_i[12:0])
			&& staged_cfg[1].second.pixel == $past(wb_dat_i[25:13]))
		else $error("output two second point layout wrong");

	start_level_a: assert property (frame_start |=> general_output_one == $past(start_level[0]))
		else $error("output one not at start level");

	toggle_hit_a: assert property (!frame_start && g_out[1].hit_first |=> general_output_two != $past(general_output_two))
		else $error("output two did not invert on match");

	vd_commit_c: cover property (vertical_drive && staged_cfg[0] != active_cfg[0]);
	toggle_c: cover property (!frame_start && (g_out[0].hit_first || g_out[0].hit_second));
	read_ack_c: cover property (wb_ack_o && !wb_we_i && mask_hit);

endmodule // gpt_toggle_regs

// *** gpt_toggle_regs_tb.sv ***
// Purpose: self-checking bench for the toggle register bank
// Assumes: registered ack; counters idle at all ones so no point matches by accident
// Notes: model keeps staged, active and pending values in arrays
`timescale 1ns/10ps
module gpt_toggle_regs_tb;
	logic        clock = 0, rst = 1, cyc = 0, stb = 0, we = 0, vd = 0, fs = 0;
	logic [9:0]  adr = 10'h000;
	logic [3:0]  sel = 4'h0, fc = 4'hF;
	logic [31:0] dat = 32'h0, rdata, q, seed = 32'hC514;
	logic [12:0] lc = 13'h1FFF, pc = 13'h1FFF;
	logic        ack, out1, out2, out1_m = 0, out2_m = 0;
	logic [31:0] model [0:255];
	logic [31:0] pend [0:15];
	logic [15:0] pv = 16'h0000;
	logic [29:0] sp [0:3];
	logic [29:0] ap [0:3];
	int          failures = 0, n_compared = 0, cycles = 0, o, i;

	gpt_toggle_regs DUT (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdata), .wb_ack_o(ack),
		.vertical_drive(vd), .frame_start(fs), .field_count(fc), .line_count(lc),
		.pixel_count(pc), .general_output_one(out1), .general_output_two(out2));

	always #50 clock = ~clock;

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			print_verdict();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] wmask(input logic [7:0] a);
		if (a == gpt_pkg::IDX_OUT1_A || a == gpt_pkg::IDX_OUT2_A) return {4'h0, gpt_pkg::MASK_WORD_A};
		if (a == gpt_pkg::IDX_OUT1_B || a == gpt_pkg::IDX_OUT2_B) return {4'h0, gpt_pkg::MASK_WORD_B};
		if (a == gpt_pkg::IDX_OUT1_C || a == gpt_pkg::IDX_OUT2_C) return {4'h0, gpt_pkg::MASK_WORD_C};
		if (a == gpt_pkg::IDX_FE_MASK) return 32'h0000FFFF;
		if (a == gpt_pkg::IDX_LEVEL_CTRL) return 32'h00000003;
		if (a <= gpt_pkg::IDX_FE_LAST) return 32'h0FFFFFFF;
		return 32'h00000000;
	endfunction

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		@(posedge clock);
		cyc <= 1;
		stb <= 1;
		we  <= w;
		adr <= {a, 2'b00};
		dat <= d;
		sel <= s;
		do
			@(posedge clock);
		while (ack !== 1'b1);
		q = rdata;
		cyc <= 0;
		stb <= 0;
		we  <= 0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		if (a > gpt_pkg::IDX_FE_LAST) model[a] = d & wmask(a);
		else if (model[gpt_pkg::IDX_FE_MASK][a[3:0]]) model[a] = d & wmask(a);
		else begin
			pend[a[3:0]] = d & wmask(a);
			pv[a[3:0]] = 1'b1;
		end
	endtask

	task automatic rdc(input logic [7:0] a);
		logic [31:0] e;
		bus(1'b0, a, 32'h0);
		e = model[a];
		if (a == gpt_pkg::IDX_LEVEL_CTRL) e = e | {28'h0, out2_m, out1_m, 2'b00};
		check($sformatf("reg %h", a), q, e);
	endtask

	task automatic vdp;
		@(posedge clock);
		vd <= 1;
		@(posedge clock);
		vd <= 0;
		for (int k = 0; k < 4; k++) ap[k] = sp[k];
		for (int k = 0; k < 16; k++) if (pv[k]) model[k] = pend[k];
		pv = 16'h0000;
	endtask

	task automatic hit(input logic [29:0] pt);
		@(posedge clock);
		{fc, lc, pc} <= pt;
		@(posedge clock);
		{fc, lc, pc} <= {4'hF, 13'h1FFF, 13'h1FFF};
		#1;
		if (pt === ap[0] || pt === ap[1]) out1_m = ~out1_m;
		if (pt === ap[2] || pt === ap[3]) out2_m = ~out2_m;
		check("out1", {31'h0, out1}, {31'h0, out1_m});
		check("out2", {31'h0, out2}, {31'h0, out2_m});
	endtask

	task automatic frame(input logic [1:0] lv);
		wr(gpt_pkg::IDX_LEVEL_CTRL, {30'h0, lv});
		@(posedge clock);
		fs <= 1;
		@(posedge clock);
		fs <= 0;
		#1;
		{out2_m, out1_m} = lv;
		check("start levels", {30'h0, out2, out1}, {30'h0, lv});
	endtask

	initial begin
		for (i = 0; i < 256; i++) model[i] = 32'h0;
		model[gpt_pkg::IDX_FE_MASK] = 32'h00001803;
		for (i = 0; i < 4; i++) sp[i] = 30'h0;
		for (i = 0; i < 4; i++) ap[i] = 30'h0;
		repeat (20) @(posedge clock);
		rst <= 0;
		for (i = 8'h54; i <= 8'h62; i++) rdc(8'(i));
		for (i = 8'h54; i <= 8'h62; i++) wr(8'(i), rnd() & wmask(8'(i)));
		for (i = 8'h54; i <= 8'h62; i++) rdc(8'(i));
		for (o = 0; o < 2; o++) begin
			wr(8'(8'h54 + 3 * o), {6'h0, 13'(o + 5), 9'h000, 4'(o + 3)});
			wr(8'(8'h55 + 3 * o), {15'h0, 4'(o + 9), 13'(o + 7)});
			wr(8'(8'h56 + 3 * o), {6'h0, 13'(o + 13), 13'(o + 11)});
			sp[2 * o] = {4'(o + 3), 13'(o + 5), 13'(o + 7)};
			sp[2 * o + 1] = {4'(o + 9), 13'(o + 11), 13'(o + 13)};
		end
		hit(sp[0]);
		vdp();
		frame(2'b01);
		for (i = 0; i < 4; i++) hit(ap[i]);
		rdc(gpt_pkg::IDX_LEVEL_CTRL);
		frame(2'b10);
		hit(ap[1]);
		wr(gpt_pkg::IDX_FE_MASK, 32'h00000001);
		wr(8'h00, rnd());
		wr(8'h01, rnd());
		rdc(8'h00);
		rdc(8'h01);
		vdp();
		rdc(8'h01);
		bus(1'b1, gpt_pkg::IDX_FE_MASK, 32'h00005A00, 4'h2);
		model[gpt_pkg::IDX_FE_MASK] = 32'h00005A01;
		bus(1'b1, 8'h00, rnd(), 4'h1);
		rdc(gpt_pkg::IDX_FE_MASK);
		rdc(8'h00);
		print_verdict();
	end
endmodule // gpt_toggle_regs_tb
